// *** hw/mcsr_map.vh ***
// Register addresses, field positions and constants of the machine register bank.
`ifndef MCSR_MAP_VH
`define MCSR_MAP_VH
`define MCSR_STATUS 12'h300
`define MCSR_TVEC 12'h305
`define MCSR_INHIBIT 12'h320
`define MCSR_SCRATCH 12'h340
`define MCSR_EPC 12'h341
`define MCSR_CFG_BASE 12'h3A0
`define MCSR_CFG_LAST 12'h3AF
`define MCSR_ADDR_BASE 12'h3B0
`define MCSR_ADDR_LAST 12'h3EF
`define MCSR_SECCFG 12'h747
`define MCSR_SECCFGH 12'h757
`define MCSR_CYCLE 12'hB00
`define MCSR_INSTRET 12'hB02
`define MCSR_HPM_FIRST 12'hB03
`define MCSR_HPM_LAST 12'hB1F
`define MCSR_CYCLEH 12'hB80
`define MCSR_INSTRETH 12'hB82
`define MCSR_HPMH_FIRST 12'hB83
`define MCSR_HPMH_LAST 12'hB9F
`define MCSR_EVT_FIRST 12'h323
`define MCSR_EVT_LAST 12'h33F
`define MCSR_TIME 12'hC01
`define MCSR_TIMEH 12'hC81
`define MCSR_IMPID 12'hF13
`define MCSR_HARTID 12'hF14
`define MCSR_CFGPTR 12'hF15
`define MCSR_STATUS_MIE 3
`define MCSR_STATUS_PREVIOUS_IRQ_ENABLE 7
`define MCSR_INH_CY 0
`define MCSR_INH_IR 2
`define MCSR_INH_RESET 32'h0000_0005
`define MCSR_SEC_MASK 32'h0000_0007
`define MCSR_SEC_STICKY 32'h0000_0003
`define MCSR_FLD_MASK 8'h9F
`define MCSR_FLD_L 7
`define MCSR_FLD_W 1
`define MCSR_FLD_R 0
`define MCSR_TVEC_MODE_MASK 32'h0000_0003
`define MCSR_TVEC_BASE_MASK 32'hFFFF_FF00
`define MCSR_ZERO 32'h0000_0000
`endif

// *** hw/mcsr_bank.v ***
// Machine register bank: identity, security, region protection, counters and trap state.
`timescale 1ns/100ps
`include "mcsr_map.vh"
module mcsr_bank #(
  parameter REGION_COUNT_PARAM = 16,
  parameter [31:0] SECCFG_RESET_PARAM = 32'h0000_0000,
  parameter [511:0] REGION_CFG_RESET_PARAM = {512{1'b0}},
  parameter [2047:0] REGION_ADDR_RESET_PARAM = {2048{1'b0}},
  parameter [31:0] TVEC_RESET = 32'h0000_0001
) (
  input wire sys_clk,
  input wire reset,
  input wire [31:0] impl_id_in,
  input wire [31:0] hart_id_in,
  input wire [31:0] boot_addr_in,
  input wire csr_access,
  input wire csr_write,
  input wire [11:0] csr_addr,
  input wire [31:0] csr_wdata,
  output reg [31:0] csr_rdata,
  output reg csr_illegal,
  input wire instr_retired,
  input wire trap_enter,
  input wire trap_is_irq,
  input wire [9:0] trap_irq_id,
  input wire [31:0] trap_pc,
  input wire mret,
  output reg pc_set,
  output reg [31:0] pc_target,
  output wire [511:0] region_cfg,
  output wire [2047:0] region_addr,
  output wire lockdown_bit,
  output wire whitelist_policy_bit,
  output wire rule_lock_bypass_bit,
  output wire global_irq_enable,
  output reg major_alert
);

  // Hardened registers and their inverted shadows, then the unshadowed inhibit, counter and boot state.
  reg [31:0] status_q;
  reg [31:0] status_n_q;
  reg [31:0] tvec_q;
  reg [31:0] tvec_n_q;
  reg [31:0] scratch_q;
  reg [31:0] scratch_n_q;
  reg [31:0] epc_q;
  reg [31:0] epc_n_q;
  reg [31:0] seccfg_q;
  reg [31:0] seccfg_n_q;
  reg [7:0] cfg_q [0:63];
  reg [7:0] cfg_n_q [0:63];
  reg [31:0] addr_q [0:63];
  reg [31:0] addr_n_q [0:63];
  reg [31:0] inhibit_q;
  reg [63:0] cycle_q;
  reg [63:0] instret_q;
  reg boot_q;
  wire wr;
  wire [5:0] cfg_idx;
  wire [5:0] addr_idx;
  reg [63:0] fld_bad;
  reg [63:0] adr_bad;
  integer i;
  // Separate loop index so the compare logic does not share a driver with the clocked process.
  integer j;

  assign wr = csr_access && csr_write && !csr_illegal;
  assign cfg_idx = {csr_addr[3:0], 2'b00};
  assign addr_idx = csr_addr[5:0] - 6'h30;
  assign lockdown_bit = seccfg_q[0];
  assign whitelist_policy_bit = seccfg_q[1];
  assign rule_lock_bypass_bit = seccfg_q[2];
  assign global_irq_enable = status_q[`MCSR_STATUS_MIE];

  // Flatten region state onto the protection outputs.
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_flat
      assign region_cfg[8*g+7:8*g] = cfg_q[g];
      assign region_addr[32*g+31:32*g] = addr_q[g];
    end
  endgenerate

  // Legalise one written region field.
  function [7:0] legal_fld;
    input [7:0] v;
    input lock;
    reg [7:0] t;
    begin
      t = v & `MCSR_FLD_MASK;
      if (!lock && !t[`MCSR_FLD_R] && t[`MCSR_FLD_W])
        t[`MCSR_FLD_W] = 1'b0;
      legal_fld = t;
    end
  endfunction

  // Illegal access detection for the unimplemented time registers.
  always @* begin
    csr_illegal = csr_access && (csr_addr == `MCSR_TIME || csr_addr == `MCSR_TIMEH);
  end

  // Read multiplexer; unlisted and hardwired addresses read zero.
  always @* begin
    csr_rdata = `MCSR_ZERO;
    case (csr_addr)
      `MCSR_IMPID: csr_rdata = impl_id_in;
      `MCSR_HARTID: csr_rdata = hart_id_in;
      `MCSR_CFGPTR: csr_rdata = `MCSR_ZERO;
      `MCSR_SECCFGH: csr_rdata = `MCSR_ZERO;
      `MCSR_SECCFG: csr_rdata = seccfg_q & `MCSR_SEC_MASK;
      `MCSR_STATUS: csr_rdata = status_q;
      `MCSR_TVEC: csr_rdata = tvec_q;
      `MCSR_SCRATCH: csr_rdata = scratch_q;
      `MCSR_EPC: csr_rdata = epc_q;
      `MCSR_INHIBIT: csr_rdata = inhibit_q;
      `MCSR_CYCLE: csr_rdata = cycle_q[31:0];
      `MCSR_CYCLEH: csr_rdata = cycle_q[63:32];
      `MCSR_INSTRET: csr_rdata = instret_q[31:0];
      `MCSR_INSTRETH: csr_rdata = instret_q[63:32];
      default: begin
        if (csr_addr >= `MCSR_CFG_BASE && csr_addr <= `MCSR_CFG_LAST) begin
          csr_rdata = {cfg_q[cfg_idx+6'd3], cfg_q[cfg_idx+6'd2],
                       cfg_q[cfg_idx+6'd1], cfg_q[cfg_idx]};
        end else if (csr_addr >= `MCSR_ADDR_BASE && csr_addr <= `MCSR_ADDR_LAST) begin
          csr_rdata = addr_q[addr_idx];
        end
      end
    endcase
  end

  // Register updates, writes, trap entry and return.
  always @(posedge sys_clk) begin
    if (reset) begin
      seccfg_q <= SECCFG_RESET_PARAM & `MCSR_SEC_MASK;
      seccfg_n_q <= ~(SECCFG_RESET_PARAM & `MCSR_SEC_MASK);
      for (i = 0; i < 64; i = i + 1) begin
        if (i < REGION_COUNT_PARAM) begin
          cfg_q[i] <= REGION_CFG_RESET_PARAM[8*i +: 8] & `MCSR_FLD_MASK;
          cfg_n_q[i] <= ~(REGION_CFG_RESET_PARAM[8*i +: 8] & `MCSR_FLD_MASK);
          addr_q[i] <= REGION_ADDR_RESET_PARAM[32*i +: 32];
          addr_n_q[i] <= ~REGION_ADDR_RESET_PARAM[32*i +: 32];
        end else begin
          cfg_q[i] <= 8'h00;
          cfg_n_q[i] <= 8'hFF;
          addr_q[i] <= `MCSR_ZERO;
          addr_n_q[i] <= ~`MCSR_ZERO;
        end
      end
      status_q <= `MCSR_ZERO;
      status_n_q <= ~`MCSR_ZERO;
      tvec_q <= TVEC_RESET;
      tvec_n_q <= ~TVEC_RESET;
      scratch_q <= `MCSR_ZERO;
      scratch_n_q <= ~`MCSR_ZERO;
      epc_q <= `MCSR_ZERO;
      epc_n_q <= ~`MCSR_ZERO;
      inhibit_q <= `MCSR_INH_RESET;
      cycle_q <= 64'h0000_0000_0000_0000;
      instret_q <= 64'h0000_0000_0000_0000;
      boot_q <= 1'b1;
      pc_set <= 1'b0;
      pc_target <= `MCSR_ZERO;
    end else begin
      boot_q <= 1'b0;
      pc_set <= 1'b0;
      if (boot_q) begin
        pc_set <= 1'b1;
        pc_target <= boot_addr_in;
      end
      if (!inhibit_q[`MCSR_INH_CY])
        cycle_q <= cycle_q + 64'h0000_0000_0000_0001;
      if (!inhibit_q[`MCSR_INH_IR] && instr_retired)
        instret_q <= instret_q + 64'h0000_0000_0000_0001;
      if (wr) begin
        case (csr_addr)
          `MCSR_SECCFG: begin
            seccfg_q <= (csr_wdata & `MCSR_SEC_MASK) | (seccfg_q & `MCSR_SEC_STICKY);
            seccfg_n_q <= ~((csr_wdata & `MCSR_SEC_MASK) | (seccfg_q & `MCSR_SEC_STICKY));
          end
          `MCSR_STATUS: begin
            status_q <= csr_wdata;
            status_n_q <= ~csr_wdata;
          end
          `MCSR_TVEC: begin
            tvec_q <= csr_wdata & (`MCSR_TVEC_BASE_MASK | `MCSR_TVEC_MODE_MASK);
            tvec_n_q <= ~(csr_wdata & (`MCSR_TVEC_BASE_MASK | `MCSR_TVEC_MODE_MASK));
          end
          `MCSR_SCRATCH: begin
            scratch_q <= csr_wdata;
            scratch_n_q <= ~csr_wdata;
          end
          `MCSR_EPC: begin
            epc_q <= csr_wdata;
            epc_n_q <= ~csr_wdata;
          end
          `MCSR_INHIBIT: inhibit_q <= csr_wdata & `MCSR_INH_RESET;
          `MCSR_CYCLE: cycle_q[31:0] <= csr_wdata;
          `MCSR_CYCLEH: cycle_q[63:32] <= csr_wdata;
          `MCSR_INSTRET: instret_q[31:0] <= csr_wdata;
          `MCSR_INSTRETH: instret_q[63:32] <= csr_wdata;
          default: begin
            if (csr_addr >= `MCSR_CFG_BASE && csr_addr <= `MCSR_CFG_LAST) begin
              for (i = 0; i < 4; i = i + 1) begin
                if ({26'd0, cfg_idx} + i < REGION_COUNT_PARAM) begin
                  cfg_q[cfg_idx + i[5:0]] <= legal_fld(csr_wdata[8*i +: 8], seccfg_q[0]);
                  cfg_n_q[cfg_idx + i[5:0]] <= ~legal_fld(csr_wdata[8*i +: 8], seccfg_q[0]);
                end
              end
            end else if (csr_addr >= `MCSR_ADDR_BASE && csr_addr <= `MCSR_ADDR_LAST) begin
              if ({26'd0, addr_idx} < REGION_COUNT_PARAM) begin
                addr_q[addr_idx] <= csr_wdata;
                addr_n_q[addr_idx] <= ~csr_wdata;
              end
            end
          end
        endcase
      end
      if (trap_enter) begin
        epc_q <= trap_pc;
        epc_n_q <= ~trap_pc;
        status_q[`MCSR_STATUS_PREVIOUS_IRQ_ENABLE] <= status_q[`MCSR_STATUS_MIE];
        status_q[`MCSR_STATUS_MIE] <= 1'b0;
        status_n_q[`MCSR_STATUS_PREVIOUS_IRQ_ENABLE] <= ~status_q[`MCSR_STATUS_MIE];
        status_n_q[`MCSR_STATUS_MIE] <= 1'b1;
        pc_set <= 1'b1;
        if (trap_is_irq && tvec_q[0])
          pc_target <= (tvec_q & `MCSR_TVEC_BASE_MASK) + {20'd0, trap_irq_id, 2'b00};
        else
          pc_target <= tvec_q & `MCSR_TVEC_BASE_MASK;
      end else if (mret) begin
        status_q[`MCSR_STATUS_MIE] <= status_q[`MCSR_STATUS_PREVIOUS_IRQ_ENABLE];
        status_n_q[`MCSR_STATUS_MIE] <= ~status_q[`MCSR_STATUS_PREVIOUS_IRQ_ENABLE];
        pc_set <= 1'b1;
        pc_target <= epc_q;
      end
    end
  end

  // Region shadow comparisons.
  always @* begin
    for (j = 0; j < 64; j = j + 1) begin
      fld_bad[j] = (cfg_q[j] != ~cfg_n_q[j]);
      adr_bad[j] = (addr_q[j] != ~addr_n_q[j]);
    end
  end

  // Alert combines every shadow mismatch in the same cycle.
  always @* begin
    major_alert = (|fld_bad) || (|adr_bad) ||
                  (status_q != ~status_n_q) || (tvec_q != ~tvec_n_q) ||
                  (scratch_q != ~scratch_n_q) || (epc_q != ~epc_n_q) ||
                  (seccfg_q != ~seccfg_n_q);
  end

endmodule

// *** sim/mcsr_bank_asserts.sv ***
// Port-level property checker for the machine register bank.
`timescale 1ns/100ps
`include "mcsr_map.vh"
module mcsr_bank_asserts #(
  parameter REGION_COUNT_PARAM = 16
) (
  input wire sys_clk,
  input wire reset,
  input wire [31:0] impl_id_in,
  input wire [31:0] hart_id_in,
  input wire csr_access,
  input wire [11:0] csr_addr,
  input wire [31:0] csr_rdata,
  input wire csr_illegal,
  input wire trap_enter,
  input wire mret,
  input wire pc_set,
  input wire [511:0] region_cfg,
  input wire [2047:0] region_addr,
  input wire lockdown_bit,
  input wire whitelist_policy_bit,
  input wire major_alert
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Flags addresses of the hardwired event counters and selectors.
  wire evt_hit = (csr_addr >= `MCSR_HPM_FIRST && csr_addr <= `MCSR_HPM_LAST) ||
    (csr_addr >= `MCSR_HPMH_FIRST && csr_addr <= `MCSR_HPMH_LAST) ||
    (csr_addr >= `MCSR_EVT_FIRST && csr_addr <= `MCSR_EVT_LAST);
  // A trap or a return is followed one cycle later by a redirect.
  sequence flow_s; trap_enter || mret; endsequence
  sequence redirect_s; ##1 pc_set; endsequence
  impid_read_a:
    assert property (csr_addr == `MCSR_IMPID |-> csr_rdata == impl_id_in) else $error("impl id");
  hartid_read_a:
    assert property (csr_addr == `MCSR_HARTID |-> csr_rdata == hart_id_in) else $error("hart id");
  cfgptr_zero_a:
    assert property (csr_addr == `MCSR_CFGPTR |-> csr_rdata == 32'h0) else $error("cfg pointer");
  seccfg_zero_a:
    assert property (csr_addr == `MCSR_SECCFG |-> csr_rdata[31:3] == 29'h0) else $error("seccfg");
  seccfgh_zero_a:
    assert property (csr_addr == `MCSR_SECCFGH |-> csr_rdata == 32'h0) else $error("seccfgh");
  event_zero_a:
    assert property (evt_hit |-> csr_rdata == 32'h0) else $error("event counter not zero");
  time_illegal_a:
    assert property (csr_illegal == (csr_access && (csr_addr == `MCSR_TIME ||
      csr_addr == `MCSR_TIMEH))) else $error("time access flag wrong");
  sticky_hold_a:
    assert property ({lockdown_bit, whitelist_policy_bit} != 2'h0 |=>
      ({lockdown_bit, whitelist_policy_bit} & $past({lockdown_bit, whitelist_policy_bit}))
      == $past({lockdown_bit, whitelist_policy_bit})) else $error("sticky bit cleared");
  region_hw_a:
    assert property ((region_cfg >> (8 * REGION_COUNT_PARAM)) == 512'h0 &&
      (region_addr >> (32 * REGION_COUNT_PARAM)) == 2048'h0) else $error("upper region set");
  field_rsvd_a:
    assert property ((region_cfg & {64{8'h60}}) == 512'h0) else $error("reserved field bits");
  trap_redirect_a:
    assert property (flow_s |-> redirect_s) else $error("no redirect after trap");
  alert_quiet_a:
    assert property (!major_alert) else $error("major alert raised");
endmodule
bind mcsr_bank mcsr_bank_asserts #(.REGION_COUNT_PARAM(REGION_COUNT_PARAM)) chk (.*);

// *** sim/mcsr_bank_bench.sv ***
// Self-checking bench for the machine register bank.
`timescale 1ns/100ps
`include "mcsr_map.vh"
module mcsr_bank_bench;
  logic sys_clk = 1'h0, reset = 1'h1, csr_access = 1'h0, csr_write = 1'h0;
  logic instr_retired = 1'h0, trap_enter = 1'h0, trap_is_irq = 1'h0, mret = 1'h0;
  logic [9:0] trap_irq_id = 10'h3;
  logic [11:0] csr_addr = 12'h0;
  logic [31:0] csr_wdata = 32'h0, trap_pc = 32'h0, csr_rdata, pc_target;
  logic [31:0] impl_id_in = 32'h1234_5678, hart_id_in = 32'h3, boot_addr_in = 32'h8000;
  logic csr_illegal, pc_set, lockdown_bit, whitelist_policy_bit, rule_lock_bypass_bit;
  logic global_irq_enable, major_alert;
  logic [511:0] region_cfg;
  logic [2047:0] region_addr;
  int n_mismatch = 0, samples_checked = 0;
  // Rows: address, write flag, write data, expected read back.
  logic [76:0] rows [0:18] = '{
    {`MCSR_INHIBIT, 1'h0, 32'h0, 32'h5},
    {`MCSR_IMPID, 1'h0, 32'h0, 32'h1234_5678},
    {`MCSR_HARTID, 1'h0, 32'h0, 32'h3},
    {`MCSR_CFGPTR, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_SECCFGH, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_CFG_BASE, 1'h1, 32'h7F7F_7F02, 32'h1F1F_1F00},
    {12'h3A3, 1'h1, 32'h0103_0507, 32'h0103_0507},
    {12'h3A4, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_ADDR_BASE, 1'h1, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
    {12'h3BF, 1'h1, 32'h1234, 32'h1234},
    {12'h3C0, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_ADDR_LAST, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_HPM_FIRST, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_HPMH_LAST, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_EVT_LAST, 1'h1, 32'hFFFF_FFFF, 32'h0},
    {`MCSR_SECCFG, 1'h1, 32'hFFFF_FFFF, 32'h7},
    {`MCSR_SECCFG, 1'h1, 32'h0, 32'h3},
    {`MCSR_CFG_BASE, 1'h1, 32'h2, 32'h2},
    {`MCSR_CFGPTR, 1'h0, 32'h0, 32'h0}};
  mcsr_bank dut (.*);
  // Clock of 10 ns period.
  always #5 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    csr_access <= 1'h1;
    csr_write <= 1'h1;
    csr_addr <= a;
    csr_wdata <= d;
    @(posedge sys_clk);
    csr_access <= 1'h0;
    csr_write <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    @(posedge sys_clk);
    csr_addr <= a;
    #1 check($sformatf("csr_%h", a), csr_rdata & m, exp);
  endtask
  // Raises a trap or return for one cycle and checks the redirect.
  task automatic fire(input logic te, irq, mr, input logic [31:0] pc, exp);
    @(posedge sys_clk);
    trap_enter <= te;
    trap_is_irq <= irq;
    mret <= mr;
    trap_pc <= pc;
    @(posedge sys_clk);
    trap_enter <= 1'h0;
    mret <= 1'h0;
    #1 check("pc_set", {31'h0, pc_set}, 32'h1);
    check("pc_target", pc_target, exp);
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog cuts a hang short.
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  // Main sequence of tests.
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    for (int i = 0; i < 4 && pc_set !== 1'h1; i++) @(posedge sys_clk) #1;
    check("boot", pc_target, 32'h8000);
    foreach (rows[i]) begin
      if (rows[i][64]) wr(rows[i][76:65], rows[i][63:32]);
      rd(rows[i][76:65], rows[i][31:0]);
    end
    check("bypass", {31'h0, rule_lock_bypass_bit}, 32'h0);
    check("lockdown", {31'h0, lockdown_bit}, 32'h1);
    @(posedge sys_clk);
    csr_access <= 1'h1;
    csr_addr <= `MCSR_TIMEH;
    #1 check("csr_illegal", {31'h0, csr_illegal}, 32'h1);
    @(posedge sys_clk);
    csr_access <= 1'h0;
    instr_retired <= 1'h1;
    wr(`MCSR_CYCLE, 32'hFFFF_FFFE);
    wr(`MCSR_INHIBIT, 32'h4);
    repeat (3) @(posedge sys_clk);
    wr(`MCSR_INHIBIT, 32'h5);
    rd(`MCSR_CYCLE, 32'h3);
    rd(`MCSR_CYCLEH, 32'h1);
    rd(`MCSR_CYCLE, 32'h3);
    rd(`MCSR_INSTRET, 32'h0);
    wr(`MCSR_INHIBIT, 32'h1);
    repeat (3) @(posedge sys_clk);
    wr(`MCSR_INHIBIT, 32'h5);
    rd(`MCSR_INSTRET, 32'h5);
    rd(`MCSR_CYCLE, 32'h3);
    wr(`MCSR_TVEC, 32'h1001);
    wr(`MCSR_STATUS, 32'h8);
    fire(1'h1, 1'h1, 1'h0, 32'h400, 32'h100C);
    rd(`MCSR_EPC, 32'h400);
    rd(`MCSR_STATUS, 32'h80, 32'h80);
    fire(1'h0, 1'h0, 1'h1, 32'h0, 32'h400);
    check("irq_enable", {31'h0, global_irq_enable}, 32'h1);
    fire(1'h1, 1'h0, 1'h0, 32'h800, 32'h1000);
    wr(`MCSR_TVEC, 32'h1000);
    fire(1'h1, 1'h1, 1'h0, 32'h900, 32'h1000);
    @(posedge sys_clk);
    reset <= 1'h1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'h0;
    rd(`MCSR_SECCFG, 32'h0);
    rd(`MCSR_INHIBIT, 32'h5);
    summarize();
  end
endmodule
